/* File: logic/pab_device.sv */
// pab_device: address decode and busy tracking of the managed device
// assumes host keeps transaction order start, command, stop
// Contract
// RULE_01: answer at base address plus offset 0..8
// RULE_02: offset from two three-state strap pins
// RULE_03: host may overwrite base address register
// RULE_04: always answer global and alert-response addresses
// RULE_05: status bit 6 low busy, high ready
// RULE_06: status read always served, never faults
// RULE_07: busy command: ack address, nack command, alert
// RULE_08: restore 30ms, log store 20ms, store mass-write
// RULE_09: log erase 175ms, log restore 2ms
// RULE_10: calibration writes busy under 500us
// RULE_11: listed config writes busy under 50us
// RULE_12: busy counted from stop to next start
// RULE_13: host polls status after each write
// RULE_14: host polls after every nonvolatile command
// RULE_15: host sends command then repeated-start read
// RULE_16: durations assume 400kHz back-to-back traffic
// RULE_17: busy from stop until processing completes
`timescale 1ns/1ps
module pab_device #(
    parameter int BUSY_SCALE = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [1:0] addr_select_pin0,
    input wire logic [1:0] addr_select_pin1,
    input wire logic internalLogReq,
    input wire logic alertClear,
    output logic busyOut,
    output logic [6:0] baseAddrOut,
    pab_link_if.device link
);
    localparam int BUSY_CNT_W = pab_pkg::BUSY_CNT_W;
    logic [6:0] baseAddr_ff;
    logic busy_ff;
    logic [BUSY_CNT_W-1:0] busyCnt_ff;
    logic [BUSY_CNT_W-1:0] pendCnt_ff;
    logic pend_ff;
    logic selected_ff;
    logic cmdOk_ff;
    logic [7:0] cmdHeld_ff;
    logic [15:0] dataHeld_ff;
    logic addrAckStb_ff;
    logic addrAck_ff;
    logic cmdAckStb_ff;
    logic cmdAck_ff;
    logic [7:0] rdData_ff;
    logic alertN_ff;

    // offset from straps, pin1 is the major digit
    wire logic [3:0] strapOffset = 4'(3 * link_strap(addr_select_pin1)
        + link_strap(addr_select_pin0)); // RULE_02
    wire logic [6:0] ownAddr = 7'(baseAddr_ff + 7'(strapOffset)); // RULE_01
    wire logic addrHit = (link.addr == ownAddr) // RULE_01
        || (link.addr == pab_pkg::GLOBAL_ADDR)
        || (link.addr == pab_pkg::ALERT_RESP_ADDR); // RULE_04
    wire logic isStatus = link.cmd == pab_pkg::CMD_STATUS_COMMON;
    wire logic cmdRefused = busy_ff && !isStatus; // RULE_06 RULE_07
    wire logic [BUSY_CNT_W-1:0] cmdTime = busy_time(link.cmd);
    wire logic [7:0] statusByte = 8'(!busy_ff) << pab_pkg::STATUS_READY_BIT; // RULE_05

    // strobes qualified by the current selection
    wire logic cmdTake = link.cmdStb && selected_ff;
    wire logic refuseNow = cmdTake && cmdRefused; // RULE_07
    wire logic setBaseNow = link.stopStb && cmdOk_ff
        && cmdHeld_ff == pab_pkg::CMD_SET_BASE; // RULE_03
    // busy entry and exit conditions
    wire logic busyFromCmd = link.stopStb && pend_ff; // RULE_12
    wire logic busyFromLog = !busy_ff && internalLogReq; // RULE_08
    wire logic busyLast = busyCnt_ff <= BUSY_CNT_W'(1); // RULE_17
    wire logic [BUSY_CNT_W-1:0] logTime =
        BUSY_CNT_W'(pab_pkg::CYC_LOG_STORE / BUSY_SCALE); // RULE_08

    function automatic logic [1:0] link_strap(input logic [1:0] pin);
        unique case (pin)
            pab_pkg::STRAP_LOW: link_strap = 2'h0;
            pab_pkg::STRAP_FLOAT: link_strap = 2'h1;
            default: link_strap = 2'h2;
        endcase
    endfunction

    // busy length for a command, zero for unlisted commands
    function automatic logic [BUSY_CNT_W-1:0] busy_time(input logic [7:0] c);
        int t;
        t = 0;
        unique case (c)
            pab_pkg::CMD_RESTORE_ALL: t = pab_pkg::CYC_RESTORE; // RULE_08
            pab_pkg::CMD_STORE_ALL: t = pab_pkg::CYC_MASS_WRITE; // RULE_08
            pab_pkg::CMD_LOG_STORE: t = pab_pkg::CYC_LOG_STORE; // RULE_08
            pab_pkg::CMD_LOG_CLEAR: t = pab_pkg::CYC_LOG_CLEAR; // RULE_09
            pab_pkg::CMD_LOG_RESTORE: t = pab_pkg::CYC_LOG_RESTORE; // RULE_09
            pab_pkg::CMD_NVM_ERASE, pab_pkg::CMD_NVM_DATA: t = pab_pkg::CYC_NVM;
            pab_pkg::CMD_IOUT_GAIN, pab_pkg::CMD_IOUT_OFFSET,
            pab_pkg::CMD_IIN_GAIN: t = pab_pkg::CYC_CAL; // RULE_10
            pab_pkg::CMD_USER_DATA0, pab_pkg::CMD_USER_DATA1,
            pab_pkg::CMD_CHAN_CONFIG, pab_pkg::CMD_RISE_TIME,
            pab_pkg::CMD_OV_LIMIT, pab_pkg::CMD_UV_LIMIT,
            pab_pkg::CMD_DAC_DIRECT: t = pab_pkg::CYC_FAST; // RULE_11
            default: t = 0;
        endcase
        busy_time = BUSY_CNT_W'(t / BUSY_SCALE); // RULE_16
    endfunction

    // address phase: ack any decoded address, busy or not
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addrAckStb_ff <= 1'b0;
            addrAck_ff <= 1'b0;
            selected_ff <= 1'b0;
        end else if (clkEn) begin
            addrAckStb_ff <= link.startStb;
            if (link.startStb) begin
                addrAck_ff <= addrHit; // RULE_07
                selected_ff <= addrHit;
            end else if (link.stopStb) begin
                selected_ff <= 1'b0;
            end
        end
    end

    // command answer: refuse while busy except status read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmdAckStb_ff <= 1'b0;
            cmdAck_ff <= 1'b0;
            rdData_ff <= 8'h00;
        end else if (clkEn) begin
            cmdAckStb_ff <= cmdTake;
            if (cmdTake) begin
                cmdAck_ff <= !cmdRefused; // RULE_07
                rdData_ff <= isStatus ? statusByte : 8'h00; // RULE_06
            end
        end
    end

    // accepted command held until stop for base write and busy entry
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmdOk_ff <= 1'b0;
            cmdHeld_ff <= 8'h00;
            dataHeld_ff <= 16'h0000;
            pend_ff <= 1'b0;
            pendCnt_ff <= '0;
        end else if (clkEn) begin
            if (cmdTake) begin
                cmdOk_ff <= !cmdRefused;
                cmdHeld_ff <= link.cmd;
                dataHeld_ff <= link.wrData;
                pend_ff <= !cmdRefused && (cmdTime != '0);
                pendCnt_ff <= cmdTime;
            end else if (link.stopStb) begin
                pend_ff <= 1'b0;
                cmdOk_ff <= 1'b0;
            end
        end
    end

    // busy starts at stop of accepted slow command, ends on count
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_ff <= 1'b0;
            busyCnt_ff <= '0;
        end else if (clkEn) begin
            if (busyFromCmd) begin
                busy_ff <= 1'b1; // RULE_12 RULE_17
                busyCnt_ff <= pendCnt_ff;
            end else if (busyFromLog) begin
                busy_ff <= 1'b1; // RULE_08
                busyCnt_ff <= logTime;
            end else if (busy_ff) begin
                if (busyLast) begin
                    busy_ff <= 1'b0; // RULE_17
                end
                busyCnt_ff <= busyCnt_ff - 1'b1;
            end
        end
    end

    // base address write takes effect at stop; alert latches low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            baseAddr_ff <= pab_pkg::BASE_ADDR_RST;
            alertN_ff <= 1'b1;
        end else if (clkEn) begin
            if (setBaseNow) begin
                baseAddr_ff <= dataHeld_ff[6:0]; // RULE_03
            end
            if (refuseNow) begin
                alertN_ff <= 1'b0; // RULE_07
            end else if (alertClear) begin
                alertN_ff <= 1'b1;
            end
        end
    end

    // link answers, all straight from flip-flops
    assign link.addrAckStb = addrAckStb_ff;
    assign link.addrAck = addrAck_ff;
    assign link.cmdAckStb = cmdAckStb_ff;
    assign link.cmdAck = cmdAck_ff;
    assign link.rdData = rdData_ff;
    assign link.alertLineN = alertN_ff;

    // local status for the system side
    assign busyOut = busy_ff;
    assign baseAddrOut = baseAddr_ff;
endmodule

/* File: shared/pab_pkg.sv */
// pab_pkg: constants for the address decode and busy tracking block
// assumes a 20 MHz system clock shared by both ends
package pab_pkg;
    localparam int CLK_HZ = 20000000;
    // addresses, 7-bit
    localparam logic [6:0] BASE_ADDR_RST = 7'h5C;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic [6:0] GLOBAL_ADDR = 7'h5B;
    localparam logic [3:0] OFFSET_MAX = 4'h8;
    // strap pin states
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    // status register busy bit position
    localparam int STATUS_READY_BIT = 6;
    // command codes
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
    localparam logic [7:0] CMD_STATUS_COMMON = 8'hD1;
    localparam logic [7:0] CMD_LOG_CLEAR = 8'hEC;
    localparam logic [7:0] CMD_LOG_STORE = 8'hEA;
    localparam logic [7:0] CMD_LOG_RESTORE = 8'hEB;
    localparam logic [7:0] CMD_IOUT_GAIN = 8'h38;
    localparam logic [7:0] CMD_IOUT_OFFSET = 8'h39;
    localparam logic [7:0] CMD_IIN_GAIN = 8'hE8;
    localparam logic [7:0] CMD_USER_DATA0 = 8'hB0;
    localparam logic [7:0] CMD_USER_DATA1 = 8'hB1;
    localparam logic [7:0] CMD_CHAN_CONFIG = 8'hD0;
    localparam logic [7:0] CMD_RISE_TIME = 8'h61;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h44;
    localparam logic [7:0] CMD_DAC_DIRECT = 8'hE0;
    localparam logic [7:0] CMD_NVM_ERASE = 8'hBD;
    localparam logic [7:0] CMD_NVM_DATA = 8'hBF;
    localparam logic [7:0] CMD_SET_BASE = 8'hE3;
    // busy times in microseconds
    localparam int T_RESTORE_US = 30000;
    localparam int T_LOG_STORE_US = 20000;
    localparam int T_LOG_CLEAR_US = 175000;
    localparam int T_LOG_RESTORE_US = 2000;
    localparam int T_MASS_WRITE_US = 20000;
    localparam int T_NVM_US = 20000;
    localparam int T_CAL_US = 500;
    localparam int T_FAST_US = 50;
    // cycle counts; calibration and fast times one cycle short
    localparam int CYC_RESTORE = T_RESTORE_US * (CLK_HZ / 1000000);
    localparam int CYC_LOG_STORE = T_LOG_STORE_US * (CLK_HZ / 1000000);
    localparam int CYC_LOG_CLEAR = T_LOG_CLEAR_US * (CLK_HZ / 1000000);
    localparam int CYC_LOG_RESTORE = T_LOG_RESTORE_US * (CLK_HZ / 1000000);
    localparam int CYC_MASS_WRITE = T_MASS_WRITE_US * (CLK_HZ / 1000000);
    localparam int CYC_NVM = T_NVM_US * (CLK_HZ / 1000000);
    localparam int CYC_CAL = T_CAL_US * (CLK_HZ / 1000000) - 1;
    localparam int CYC_FAST = T_FAST_US * (CLK_HZ / 1000000) - 1;
    localparam int BUSY_CNT_W = 22;
    // transaction kinds on the link
    typedef enum logic [1:0] {
        PAB_XFER_WRITE = 2'h0,
        PAB_XFER_SEND = 2'h1,
        PAB_XFER_READ = 2'h2
    } pab_xfer_e;
endpackage

/* File: shared/pab_link_if.sv */
// pab_link_if: abstracted bus transaction link between host and device
// assumes both ends on ref_clk; one transaction phase per strobe
`timescale 1ns/1ps
interface pab_link_if;
    logic startStb;   // start of a transaction with address
    logic [6:0] addr;
    logic [1:0] kind;
    logic cmdStb;     // command byte present
    logic [7:0] cmd;
    logic [15:0] wrData;
    logic stopStb;    // stop condition
    logic addrAckStb;
    logic addrAck;
    logic cmdAckStb;
    logic cmdAck;
    logic [7:0] rdData;
    logic alertLineN;
    modport device (
        input startStb, addr, kind, cmdStb, cmd, wrData, stopStb,
        output addrAckStb, addrAck, cmdAckStb, cmdAck, rdData, alertLineN
    );
    modport host (
        output startStb, addr, kind, cmdStb, cmd, wrData, stopStb,
        input addrAckStb, addrAck, cmdAckStb, cmdAck, rdData, alertLineN
    );
endinterface

/* File: logic/pab_host.sv */
// pab_host: host end that issues transactions and polls busy
// assumes the device answers address and command one cycle after strobe
`timescale 1ns/1ps
module pab_host (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic reqValid,
    input wire logic [6:0] reqAddr,
    input wire logic [1:0] reqKind,
    input wire logic [7:0] reqCmd,
    input wire logic [15:0] reqData,
    output logic reqReady,
    output logic doneStb,
    output logic doneOk,
    output logic [7:0] doneRdData,
    pab_link_if.host link
);
    typedef enum logic [2:0] {
        PAB_IDLE = 3'b000,
        PAB_ADDR = 3'b001,
        PAB_CMD = 3'b011,
        PAB_STOP = 3'b010,
        PAB_POLL = 3'b110,
        PAB_POLLCMD = 3'b111
    } pab_hstate_e;
    pab_hstate_e state_ff;
    logic [6:0] addr_ff;
    logic [1:0] kind_ff;
    logic [7:0] cmd_ff;
    logic [15:0] data_ff;
    logic start_ff, cmdS_ff, stop_ff, ok_ff, done_ff;
    logic [7:0] rd_ff;

    wire logic gotAddr = link.addrAckStb;
    wire logic gotCmd = link.cmdAckStb;
    wire logic readyBit = link.rdData[pab_pkg::STATUS_READY_BIT];

    // sequencer: write, then poll status until ready
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= PAB_IDLE;
            {start_ff, cmdS_ff, stop_ff, ok_ff, done_ff} <= 5'h00;
            addr_ff <= 7'h00;
            kind_ff <= 2'h0;
            cmd_ff <= 8'h00;
            data_ff <= 16'h0000;
            rd_ff <= 8'h00;
        end else if (clkEn) begin
            start_ff <= 1'b0;
            cmdS_ff <= 1'b0;
            stop_ff <= 1'b0;
            done_ff <= 1'b0;
            unique case (state_ff)
                PAB_IDLE: if (reqValid) begin
                    addr_ff <= reqAddr;
                    kind_ff <= reqKind;
                    cmd_ff <= reqCmd;
                    data_ff <= reqData;
                    start_ff <= 1'b1;
                    state_ff <= PAB_ADDR;
                end
                PAB_ADDR: if (gotAddr) begin
                    if (link.addrAck) begin
                        cmdS_ff <= 1'b1; // RULE_15
                        state_ff <= PAB_CMD;
                    end else begin
                        stop_ff <= 1'b1;
                        ok_ff <= 1'b0;
                        state_ff <= PAB_STOP;
                    end
                end
                PAB_CMD: if (gotCmd) begin
                    stop_ff <= 1'b1;
                    ok_ff <= link.cmdAck;
                    rd_ff <= link.rdData;
                    state_ff <= PAB_STOP;
                end
                PAB_STOP: begin
                    if (ok_ff && kind_ff != pab_pkg::PAB_XFER_READ) begin
                        start_ff <= 1'b1; // RULE_13 RULE_14
                        state_ff <= PAB_POLL;
                    end else begin
                        done_ff <= 1'b1;
                        state_ff <= PAB_IDLE;
                    end
                end
                PAB_POLL: if (gotAddr) begin
                    if (link.addrAck) begin
                        cmdS_ff <= 1'b1;
                        state_ff <= PAB_POLLCMD;
                    end else begin
                        // address moved by the write just done: nothing to wait on
                        stop_ff <= 1'b1;
                        done_ff <= 1'b1;
                        state_ff <= PAB_IDLE;
                    end
                end
                PAB_POLLCMD: if (gotCmd) begin
                    stop_ff <= 1'b1;
                    if (readyBit) begin
                        done_ff <= 1'b1; // RULE_13
                        state_ff <= PAB_IDLE;
                    end else begin
                        state_ff <= PAB_STOP;
                    end
                end
                default: state_ff <= PAB_IDLE;
            endcase
        end
    end

    // link drive; polls use the status command code
    wire logic polling = state_ff == PAB_POLL || state_ff == PAB_POLLCMD;
    assign link.startStb = start_ff;
    assign link.addr = addr_ff;
    assign link.kind = polling ? pab_pkg::PAB_XFER_READ : kind_ff;
    assign link.cmd = polling ? pab_pkg::CMD_STATUS_COMMON : cmd_ff;
    assign link.wrData = data_ff;
    assign link.cmdStb = cmdS_ff;
    assign link.stopStb = stop_ff;
    assign reqReady = state_ff == PAB_IDLE;
    assign doneStb = done_ff;
    assign doneOk = ok_ff;
    assign doneRdData = rd_ff;
endmodule

/* File: tb/pab_link_props.sv */
// pab_link_props: timing checks on the host to device link
// assumes it watches the single link joining both design ends
`timescale 1ns/1ps
module pab_link_props (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic startStb,
    input wire logic [6:0] addr,
    input wire logic cmdStb,
    input wire logic [7:0] cmd,
    input wire logic addrAckStb,
    input wire logic addrAck,
    input wire logic cmdAckStb,
    input wire logic cmdAck,
    input wire logic alertLineN
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // steps of a transaction seen on the link
    sequence s_start;
        startStb;
    endsequence
    sequence s_status;
        cmdStb && addrAck && cmd == pab_pkg::CMD_STATUS_COMMON;
    endsequence
    sequence s_refuse;
        cmdAckStb && !cmdAck;
    endsequence
    // answer timing and strobe shape
    a_addr_answer: assert property (s_start |=> addrAckStb)
        else $error("address answer missing");
    a_ack_cause: assert property (addrAckStb |-> $past(startStb))
        else $error("address answer without start");
    a_ack_single: assert property (addrAckStb |=> !addrAckStb)
        else $error("address answer longer than a cycle");
    // fixed addresses always answered
    a_global_ack: assert property (startStb && addr == pab_pkg::GLOBAL_ADDR |=> addrAck)
        else $error("global address refused");
    a_alert_resp: assert property (startStb && addr == pab_pkg::ALERT_RESP_ADDR |=> addrAck)
        else $error("alert response address refused");
    // status read served, refusals raise alert
    a_cmd_answer: assert property (cmdStb && addrAck |=> cmdAckStb)
        else $error("command answer missing");
    a_status_served: assert property (s_status |=> cmdAck)
        else $error("status read refused");
    a_refuse_alert: assert property (s_refuse |-> ##[0:1] !alertLineN)
        else $error("refusal without alert");
    a_alert_cause: assert property ($fell(alertLineN) |-> s_refuse)
        else $error("alert without refusal");
endmodule

/* File: tb/pmbus_address_and_busy_control_tb.sv */
// pmbus_address_and_busy_control_tb: host and device joined by one link
// assumes busy counts divided by SC through the device parameter
`timescale 1ns/1ps
module pmbus_address_and_busy_control_tb;
    localparam int SC = 100;
    localparam logic [7:0] SLOW [16] = '{pab_pkg::CMD_IOUT_GAIN, pab_pkg::CMD_IOUT_OFFSET,
        pab_pkg::CMD_IIN_GAIN, pab_pkg::CMD_USER_DATA0, pab_pkg::CMD_USER_DATA1,
        pab_pkg::CMD_CHAN_CONFIG, pab_pkg::CMD_RISE_TIME, pab_pkg::CMD_OV_LIMIT,
        pab_pkg::CMD_UV_LIMIT, pab_pkg::CMD_DAC_DIRECT, pab_pkg::CMD_STORE_ALL,
        pab_pkg::CMD_LOG_STORE, pab_pkg::CMD_LOG_RESTORE, pab_pkg::CMD_NVM_ERASE,
        pab_pkg::CMD_NVM_DATA, pab_pkg::CMD_LOG_CLEAR};
    localparam int SLOW_CYC [16] = '{pab_pkg::CYC_CAL / SC, pab_pkg::CYC_CAL / SC,
        pab_pkg::CYC_CAL / SC, pab_pkg::CYC_FAST / SC, pab_pkg::CYC_FAST / SC,
        pab_pkg::CYC_FAST / SC, pab_pkg::CYC_FAST / SC, pab_pkg::CYC_FAST / SC,
        pab_pkg::CYC_FAST / SC, pab_pkg::CYC_FAST / SC, pab_pkg::CYC_MASS_WRITE / SC,
        pab_pkg::CYC_LOG_STORE / SC, pab_pkg::CYC_LOG_RESTORE / SC, pab_pkg::CYC_NVM / SC,
        pab_pkg::CYC_NVM / SC, pab_pkg::CYC_LOG_CLEAR / SC};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] strap0 = 2'h0;
    logic [1:0] strap1 = 2'h0;
    logic logReq = 1'b0;
    logic alertClr = 1'b0;
    logic reqValid = 1'b0;
    logic [6:0] reqAddr = 7'h00;
    logic [1:0] reqKind = 2'h0;
    logic [7:0] reqCmd = 8'h00;
    logic [15:0] reqData = 16'h0000;
    logic reqReady, doneStb, doneOk, busy, rOk, sawBusy;
    logic [7:0] doneRd, rRd;
    logic [6:0] baseAddr;
    logic [6:0] devAddr = 7'h5C;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    pab_link_if link ();
    pab_device #(.BUSY_SCALE(SC)) u_pab_device (.ref_clk(ref_clk), .srst(srst), .clkEn(1'b1),
        .addr_select_pin0(strap0), .addr_select_pin1(strap1), .internalLogReq(logReq),
        .alertClear(alertClr), .busyOut(busy), .baseAddrOut(baseAddr), .link(link));
    pab_host u_pab_host (.ref_clk(ref_clk), .srst(srst), .clkEn(1'b1), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqKind(reqKind), .reqCmd(reqCmd), .reqData(reqData),
        .reqReady(reqReady), .doneStb(doneStb), .doneOk(doneOk), .doneRdData(doneRd),
        .link(link));
    pab_link_props u_pab_link_props (.ref_clk(ref_clk), .srst(srst), .startStb(link.startStb),
        .addr(link.addr), .cmdStb(link.cmdStb), .cmd(link.cmd), .addrAckStb(link.addrAckStb),
        .addrAck(link.addrAck), .cmdAckStb(link.cmdAckStb), .cmdAck(link.cmdAck),
        .alertLineN(link.alertLineN));
    // clock and cycle count
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic summarize;
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic hang;
        chk("bounded wait", 16'h0, 16'h1);
        summarize();
    endtask
    // one whole transaction through the host, result kept in rOk and rRd
    task automatic xfer(input logic [6:0] a, input logic [1:0] k, input logic [7:0] c,
                        input logic [15:0] d);
        int i;
        reqAddr = a;
        reqKind = k;
        reqCmd = c;
        reqData = d;
        reqValid = 1'b1;
        sawBusy = 1'b0;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (reqReady !== 1'b1 && i < 20);
        if (reqReady !== 1'b1) hang();
        #1 reqValid = 1'b0;
        // the host polls slow commands itself, so done can take a whole busy time
        i = 0;
        while (doneStb !== 1'b1 && i < 40000) begin
            tick(1);
            i++;
            if (busy === 1'b1) sawBusy = 1'b1;
        end
        if (doneStb !== 1'b1) hang();
        rOk = doneOk;
        rRd = doneRd;
        tick(1);
    endtask
    task automatic rdStatus;
        xfer(devAddr, pab_pkg::PAB_XFER_READ, pab_pkg::CMD_STATUS_COMMON, 16'h0000);
    endtask
    // read status until the ready bit is set
    task automatic poll;
        int i;
        i = 0;
        do begin
            rdStatus();
            i++;
        end while (rRd[6] !== 1'b1 && i < 3000);
        if (rRd[6] !== 1'b1) hang();
    endtask
    // strap sweep over all nine offsets plus the fixed addresses
    task automatic t_decode;
        for (int p1 = 0; p1 < 3; p1++) begin
            for (int p0 = 0; p0 < 3; p0++) begin
                strap0 = 2'(p0);
                strap1 = 2'(p1);
                tick(2);
                devAddr = 7'h5C + 7'(3 * p1 + p0);
                rdStatus();
                chk("own address", 16'(rOk), 16'h1);
                chk("ready bit", 16'(rRd[6]), 16'h1);
                xfer(devAddr + 7'h01, pab_pkg::PAB_XFER_READ, pab_pkg::CMD_STATUS_COMMON, 16'h0);
                chk("next address", 16'(rOk), 16'h0);
            end
        end
        xfer(pab_pkg::GLOBAL_ADDR, pab_pkg::PAB_XFER_READ, pab_pkg::CMD_STATUS_COMMON, 16'h0);
        chk("global address", 16'(rOk), 16'h1);
        xfer(pab_pkg::ALERT_RESP_ADDR, pab_pkg::PAB_XFER_READ, pab_pkg::CMD_STATUS_COMMON, 16'h0);
        chk("alert address", 16'(rOk), 16'h1);
    endtask
    // move the base, check old and new addresses, then move it back
    task automatic t_base;
        xfer(devAddr, pab_pkg::PAB_XFER_WRITE, pab_pkg::CMD_SET_BASE, 16'h0020);
        devAddr = 7'h28;
        poll();
        chk("base value", 16'(baseAddr), 16'h0020);
        xfer(7'h64, pab_pkg::PAB_XFER_READ, pab_pkg::CMD_STATUS_COMMON, 16'h0);
        chk("old address", 16'(rOk), 16'h0);
        xfer(devAddr, pab_pkg::PAB_XFER_WRITE, pab_pkg::CMD_SET_BASE, 16'h005C);
        devAddr = 7'h64;
        poll();
    endtask
    // long restore, then refusal, alert and status read while busy
    task automatic t_busy;
        int t0;
        t0 = cyc;
        xfer(devAddr, pab_pkg::PAB_XFER_SEND, pab_pkg::CMD_RESTORE_ALL, 16'h0);
        chk("busy after stop", 16'(sawBusy), 16'h1);
        chk("restore length", 16'(cyc - t0 >= pab_pkg::CYC_RESTORE / SC - 20 &&
            cyc - t0 <= pab_pkg::CYC_RESTORE / SC + 40), 16'h1);
        chk("idle again", 16'(busy), 16'h0);
        // internal log store makes the device busy without a host poll
        logReq = 1'b1;
        tick(1);
        logReq = 1'b0;
        xfer(devAddr, pab_pkg::PAB_XFER_WRITE, pab_pkg::CMD_USER_DATA0, 16'h1234);
        chk("refused write", 16'(rOk), 16'h0);
        chk("address acked", 16'(link.addrAck), 16'h1);
        chk("alert low", 16'(link.alertLineN), 16'h0);
        rdStatus();
        chk("status served", 16'(rOk), 16'h1);
        chk("busy bit", 16'(rRd[6]), 16'h0);
        alertClr = 1'b1;
        tick(1);
        alertClr = 1'b0;
        chk("alert released", 16'(link.alertLineN), 16'h1);
        poll();
        xfer(devAddr, pab_pkg::PAB_XFER_WRITE, pab_pkg::CMD_USER_DATA0, 16'h1234);
        chk("accepted after", 16'(rOk), 16'h1);
        poll();
    endtask
    // every slow command except restore enters busy for its listed time
    task automatic t_slow;
        int t0;
        for (int i = 0; i < 16; i++) begin
            t0 = cyc;
            xfer(devAddr, i < 10 ? 2'(pab_pkg::PAB_XFER_WRITE) : 2'(pab_pkg::PAB_XFER_SEND),
                SLOW[i], 16'h00A5);
            chk("slow busy", 16'(sawBusy), 16'h1);
            poll();
            chk("slow length", 16'(cyc - t0 >= SLOW_CYC[i] - 20 &&
                cyc - t0 <= SLOW_CYC[i] + 40), 16'h1);
        end
    endtask
    // internal log store also holds the device busy
    task automatic t_log;
        logReq = 1'b1;
        tick(1);
        logReq = 1'b0;
        tick(1);
        chk("log busy", 16'(busy), 16'h1);
        rdStatus();
        chk("log busy bit", 16'(rRd[6]), 16'h0);
        poll();
    endtask
    // main sequence
    initial begin
        tick(6);
        srst = 1'b0;
        t_decode();
        t_base();
        t_busy();
        t_slow();
        t_log();
        summarize();
    end
endmodule
